//--- core/scr_receiver.v
// Purpose: synchronous serial character receiver with sync hunt
// Assumes: all pins but reset_n and fifoReady are asynchronous to core_clk; bit clock is slow
// Notes: every output is registered; characters also queue in a fifo
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_receiver
(
   input wire core_clk,
   input wire reset_n,
   input wire rxBitClock,
   input wire serialRxInput,
   input wire syncHuntIn,
   output reg syncHuntOut,
   output reg syncHuntOe,
   input wire masterClear,
   input wire chipDisableLine,
   input wire charReadyClear_n,
   input wire statusFlagClear_n,
   input wire controlLoadStrobe_n,
   input wire matchLoadStrobe_n,
   input wire evenParitySelect,
   input wire parityOffSelect,
   input wire [2:0] rxModeSelect,
   input wire [1:0] wordLengthSelect,
   input wire [7:0] matchCharInputs,
   output reg [7:0] holdData,
   output reg holdParity,
   output reg charReadyFlag,
   output reg overrunFlag,
   output reg parityErrorFlag,
   output reg matchFlag,
   output reg framingErrorFlag,
   output reg syncLocked,
   output reg fifoSpaceOk,
   output reg [7:0] fifoData,
   output reg fifoValid,
   input wire fifoReady
);

   // ==========================================================
   // state codes, one-hot
   // ==========================================================
   localparam [2:0] ST_TRANSP = 3'h1; // waiting, holding follows shifter
   localparam [2:0] ST_HUNT = 3'h2; // searching for the match character
   localparam [2:0] ST_LOCKED = 3'h4; // character synchronised

   // ==========================================================
   // helpers
   // ==========================================================
   // bits in one character: data bits plus an optional parity bit
   function [3:0] charLen;
      input [1:0] word_length_select;
      input parOff;
      begin
         charLen = `SCR_MIN_DATA_BITS + {2'h0, word_length_select} + {3'h0, ~parOff};
      end
   endfunction

   // right-justified data bits of the character now in the shifter
   function [7:0] charData;
      input [8:0] sh;
      input [1:0] word_length_select;
      input parOff;
      reg [8:0] aligned;
      reg [3:0] len;
      reg [7:0] mask;
      begin
         len = charLen(word_length_select, parOff);
         aligned = sh >> (4'h9 - len);
         mask = 8'hFF >> (2'h3 - word_length_select);
         charData = aligned[7:0] & mask;
      end
   endfunction

   // ==========================================================
   // declarations
   // ==========================================================
   wire [`SCR_PIN_W-1:0] pinsRaw; // bundle entering the synchroniser
   wire [`SCR_PIN_W-1:0] pins; // bundle after two flip-flops
   reg bitClkPrev; // last sampled bit clock level
   reg huntPrev; // last sampled hunt level
   reg [2:0] state; // one-hot receiver state
   reg [2:0] next_state;
   reg [8:0] shifter; // receive shift register, newest bit at top
   reg [3:0] bitCount; // bits received in the current character
   reg [7:0] matchChar; // stored match character
   reg ctlEpe; // control latch: even parity
   reg ctlPi; // control latch: parity off
   reg [2:0] ctlRms; // control latch: receive mode
   reg [1:0] ctlWls; // control latch: word length
   reg rdyInt; // internal ready flag
   reg ovrInt; // internal overrun flag
   reg perInt; // internal parity error flag
   reg [1:0] pinAge; // edges since reset, saturates once pins are real

   wire bitClk = pins[`SCR_P_BITCLK];
   wire rxData = pins[`SCR_P_DATA];
   wire hunt = pins[`SCR_P_HUNT];
   wire mclr = pins[`SCR_P_MCLR];
   wire cd = pins[`SCR_P_CD];
   wire pinsLive = &pinAge; // synchroniser and edge history hold real levels
   wire bitFall = bitClkPrev && !bitClk; // one-cycle shift strobe
   wire huntRise = hunt && !huntPrev && pinsLive;
   wire huntFall = !hunt && huntPrev;
   wire [8:0] nextShift = {rxData, shifter[8:1]};
   wire [3:0] curLen = charLen(ctlWls, ctlPi);
   wire [7:0] nextData = charData(nextShift, ctlWls, ctlPi);
   wire nextPar = nextShift[8] & ~ctlPi;
   wire lastBit = bitFall && (bitCount == curLen - 4'h1);
   wire doTransfer = (state == ST_LOCKED) && lastBit;
   wire huntHit = (state == ST_HUNT) && bitFall && (nextData == matchChar);
   wire rdyClr = !pins[`SCR_P_DRR] && !cd && pinsLive;
   wire stsClr = !pins[`SCR_P_SFR] && !cd && pinsLive;
   wire parBad = ^nextData ^ nextShift[8] ^ ~ctlEpe; // odd or even sense
   wire fifoInReady;
   wire fifoOutValid;
   wire [7:0] fifoOutData;
   wire drainTake = fifoOutValid && (!fifoValid || fifoReady);

   // the hunt pin is driven from a three-state source outside, so it
   // is sampled whatever chip disable says; we never drive it back
   assign pinsRaw = {matchCharInputs, wordLengthSelect, rxModeSelect,
                     parityOffSelect, evenParitySelect, matchLoadStrobe_n,
                     controlLoadStrobe_n, statusFlagClear_n, charReadyClear_n,
                     chipDisableLine, masterClear, syncHuntIn, serialRxInput,
                     rxBitClock};

   // ==========================================================
   // pin synchronisation
   // ==========================================================
   scr_sync2 #(.WIDTH(`SCR_PIN_W)) pinSync
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .asyncIn(pinsRaw),
      .syncOut(pins)
   );

   // ==========================================================
   // edge detection on synchronised levels
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         bitClkPrev <= 1'b0;
         huntPrev <= 1'b0;
         pinAge <= 2'h0;
      end
      else
      begin
         bitClkPrev <= bitClk;
         huntPrev <= hunt;
         if (!pinsLive)
            pinAge <= pinAge + 2'h1;
      end
   end

   // ==========================================================
   // control latches: transparent while the strobe is low
   // ==========================================================
   // master clear is deliberately absent here so settings survive it
   always @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         ctlEpe <= `SCR_EPE_RST;
         ctlPi <= `SCR_PI_RST;
         ctlRms <= `SCR_RMS_RST;
         ctlWls <= `SCR_WLS_RST;
      end
      // the synchroniser shows zeros just after reset; loading those
      // would wreck the settings, so wait until the pins are real
      else if (pinsLive && !pins[`SCR_P_CRL] && !cd)
      begin
         ctlEpe <= pins[`SCR_P_EPE];
         ctlPi <= pins[`SCR_P_PI];
         ctlRms <= pins[`SCR_P_RMS_HI:`SCR_P_RMS_LO];
         ctlWls <= pins[`SCR_P_WLS_HI:`SCR_P_WLS_LO];
      end
   end

   // ==========================================================
   // match character latch
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n)
         matchChar <= `SCR_MATCH_RST;
      else if (mclr)
         matchChar <= `SCR_MATCH_RST;
      else if (pinsLive && !pins[`SCR_P_MATCH_LOAD_STROBE] && !cd)
         matchChar <= pins[`SCR_P_MHR_HI:`SCR_P_MHR_LO];
   end

   // ==========================================================
   // next-state logic
   // ==========================================================
   always @*
   begin
      next_state = state;
      case (state)
         ST_TRANSP:
         begin
            // only internal character sync mode arms the hunt
            if (huntRise && ctlRms[0])
               next_state = ST_HUNT;
         end
         ST_HUNT:
         begin
            if (huntFall)
               next_state = ST_TRANSP;
            else if (huntHit)
               next_state = ST_LOCKED;
         end
         ST_LOCKED:
         begin
            if (huntFall)
               next_state = ST_TRANSP;
         end
         default:
            next_state = ST_TRANSP;
      endcase
   end

   // ==========================================================
   // state register, shifter and bit counter
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n || mclr)
      begin
         state <= ST_TRANSP;
         shifter <= `SCR_SHIFT_RST; // all ones, so the transparent view shows ones
         bitCount <= {`SCR_CNT_W{1'b0}};
      end
      else
      begin
         state <= next_state;
         if (bitFall)
            shifter <= nextShift;
         // counting starts fresh after a match and wraps each character
         if (huntHit || lastBit)
            bitCount <= {`SCR_CNT_W{1'b0}};
         else if (bitFall)
            bitCount <= bitCount + 4'h1;
      end
   end

   // ==========================================================
   // holding register and status flags
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n || mclr)
      begin
         holdData <= `SCR_HOLD_CLEAR;
         holdParity <= 1'b1;
         rdyInt <= 1'b0;
         ovrInt <= 1'b0;
         perInt <= 1'b0;
         matchFlag <= 1'b0;
         framingErrorFlag <= 1'b0;
      end
      else
      begin
         // transparent while not locked; the match character itself
         // lands here on the hit and is then frozen
         if (state != ST_LOCKED || doTransfer)
         begin
            holdData <= charData(shifter, ctlWls, ctlPi);
            holdParity <= shifter[8] & ~ctlPi;
         end
         if (doTransfer || huntHit)
         begin
            holdData <= nextData;
            holdParity <= nextPar;
         end
         // match flag updates at each final bit while locked and on the hunt hit
         if (huntHit)
            matchFlag <= 1'b1;
         else if (doTransfer)
            matchFlag <= (nextData == matchChar);
         // set wins over clear on every flag below
         if (doTransfer)
            rdyInt <= 1'b1;
         else if (rdyClr)
            rdyInt <= 1'b0;
         if (doTransfer && rdyInt && !rdyClr)
            ovrInt <= 1'b1;
         else if (stsClr)
            ovrInt <= 1'b0;
         if (doTransfer && !ctlPi && parBad)
            perInt <= 1'b1;
         else if (stsClr)
            perInt <= 1'b0;
         framingErrorFlag <= 1'b0; // no framing in synchronous mode
      end
   end

   // ==========================================================
   // registered outputs; only overrun and parity error are gated by chip disable
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         charReadyFlag <= 1'b0;
         overrunFlag <= 1'b0;
         parityErrorFlag <= 1'b0;
         syncLocked <= 1'b0;
         syncHuntOut <= 1'b0;
         syncHuntOe <= 1'b0;
         fifoSpaceOk <= 1'b0;
      end
      else
      begin
         charReadyFlag <= rdyInt;
         overrunFlag <= ovrInt && !cd;
         parityErrorFlag <= perInt && !cd;
         syncLocked <= (state == ST_LOCKED);
         syncHuntOut <= 1'b0; // line is an input in sync mode
         syncHuntOe <= 1'b0;
         fifoSpaceOk <= fifoInReady;
      end
   end

   // ==========================================================
   // character queue
   // ==========================================================
   // a full queue drops the character from the queue only; the
   // holding register and overrun flag still follow the pins
   scr_fifo #(.WIDTH(`SCR_CHAR_W), .DEPTH(`SCR_FIFO_DEPTH), .AW(4)) charQueue
   (
      .core_clk(core_clk),
      .reset_n(reset_n && !mclr),
      .inValid(doTransfer),
      .inReady(fifoInReady),
      .inData(nextData),
      .outValid(fifoOutValid),
      .outReady(drainTake),
      .outData(fifoOutData)
   );

   // ==========================================================
   // output stage of the queue, so the port comes from a flop
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n || mclr)
         fifoValid <= 1'b0;
      else if (drainTake)
         fifoValid <= 1'b1;
      else if (fifoReady)
         fifoValid <= 1'b0;
   end

   // data port mirrors the drain register
   always @(posedge core_clk)
   begin
      if (!reset_n)
         fifoData <= 8'h00;
      else if (drainTake)
         fifoData <= fifoOutData;
   end
endmodule

//--- common/scr_regs.vh
// Purpose: constants for the synchronous character receiver
// Assumes: included by bare name from the receiver core only
// Notes: field positions and the main reset values and widths live here
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// ==========================================================
// widths
// ==========================================================
`define SCR_CHAR_W 8
`define SCR_SHIFT_W 9
`define SCR_CNT_W 4
`define SCR_FIFO_DEPTH 16
`define SCR_PIN_W 24

// ==========================================================
// reset values
// ==========================================================
`define SCR_HOLD_CLEAR 8'hFF
`define SCR_MATCH_RST 8'h00
`define SCR_SHIFT_RST 9'h1FF
`define SCR_WLS_RST 2'h3
`define SCR_RMS_RST 3'h1
`define SCR_EPE_RST 1'h0
`define SCR_PI_RST 1'h1
`define SCR_MIN_DATA_BITS 4'h5

// ==========================================================
// positions in the synchronised pin bundle
// ==========================================================
`define SCR_P_BITCLK 0
`define SCR_P_DATA 1
`define SCR_P_HUNT 2
`define SCR_P_MCLR 3
`define SCR_P_CD 4
`define SCR_P_DRR 5
`define SCR_P_SFR 6
`define SCR_P_CRL 7
`define SCR_P_MATCH_LOAD_STROBE 8
`define SCR_P_EPE 9
`define SCR_P_PI 10
`define SCR_P_RMS_LO 11
`define SCR_P_RMS_HI 13
`define SCR_P_WLS_LO 14
`define SCR_P_WLS_HI 15
`define SCR_P_MHR_LO 16
`define SCR_P_MHR_HI 23

`endif

//--- core/scr_sync2.v
// Purpose: two flip-flop synchroniser for a bundle of pins
// Assumes: every bit is an independent level from outside the clock
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module scr_sync2
#(
   parameter WIDTH = 1
)
(
   input wire core_clk,
   input wire reset_n,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stageOne; // metastable stage, read by syncOut only

   // ==========================================================
   // two-stage capture
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         stageOne <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end
      else
      begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end
endmodule

//--- core/scr_fifo.v
// Purpose: small first-in first-out buffer for received characters
// Assumes: one clock, synchronous active-low reset
// Notes: read data is shown ahead from the head entry
`timescale 1ns/1ps
module scr_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
)
(
   input wire core_clk,
   input wire reset_n,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);

   reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage array
   reg [AW-1:0] wrPtr; // next slot to write
   reg [AW-1:0] rdPtr; // head slot
   reg [AW:0] count; // entries held

   wire doPush = inValid && inReady;
   wire doPop = outValid && outReady;

   assign inReady = (count != DEPTH[AW:0]); // honest full
   assign outValid = (count != {(AW+1){1'b0}}); // honest empty
   assign outData = mem[rdPtr];

   // ==========================================================
   // storage write, no reset needed on data
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (doPush)
         mem[wrPtr] <= inData;
   end

   // ==========================================================
   // pointers and occupancy
   // ==========================================================
   always @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (doPush)
            wrPtr <= wrPtr + 1'b1;
         if (doPop)
            rdPtr <= rdPtr + 1'b1;
         if (doPush && !doPop)
            count <= count + 1'b1;
         else if (doPop && !doPush)
            count <= count - 1'b1;
      end
   end
endmodule

//--- tb/scr_checker.sv
// Purpose: port-level assertions for the sync character receiver
// Assumes: sees only top ports; one clock, synchronous reset_n
// Notes: pin inputs pass two flops, so gating is judged after settling
`timescale 1ns/1ps
module scr_checker
(
   input wire core_clk,
   input wire reset_n,
   input wire syncHuntIn,
   input wire syncHuntOe,
   input wire masterClear,
   input wire chipDisableLine,
   input wire parityOffSelect,
   input wire [7:0] holdData,
   input wire charReadyFlag,
   input wire overrunFlag,
   input wire parityErrorFlag,
   input wire matchFlag,
   input wire syncLocked,
   input wire fifoSpaceOk
);
   // ==========================================
   // assertions
   // ==========================================
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   hunt_pin_input_a: assert property (syncHuntOe == 1'b0)
      else $error("sync hunt pin driven");
   ready_needs_lock_a: assert property ($rose(charReadyFlag) |-> syncLocked)
      else $error("ready raised without lock");
   lock_match_a: assert property ($rose(syncLocked) |-> ##[0:2] matchFlag)
      else $error("lock without match");
   lock_no_ready_a: assert property ($rose(syncLocked) && !charReadyFlag
      |=> !charReadyFlag)
      else $error("ready raised for sync");
   overrun_cause_a: assert property ($rose(overrunFlag) |-> $past(charReadyFlag))
      else $error("overrun without pending ready");
   error_gate_a: assert property (chipDisableLine [*4] |-> !overrunFlag && !parityErrorFlag)
      else $error("error flags shown while disabled");
   hunt_drop_a: assert property (!syncHuntIn [*6] |-> !syncLocked)
      else $error("lock kept after hunt fall");
   clear_idle_a: assert property (masterClear [*5] |->
      holdData == 8'hFF && !charReadyFlag
      && !matchFlag && !syncLocked && !overrunFlag && !parityErrorFlag)
      else $error("master clear state wrong");
   parity_off_a: assert property (parityOffSelect [*6] |-> !$rose(parityErrorFlag))
      else $error("parity error with parity off");
   hold_ready_a: assert property (syncLocked && $past(syncLocked) && $changed(holdData)
      && !$past(masterClear, 3) |=> charReadyFlag)
      else $error("locked transfer without ready");
   // main scenarios reached
   cover property ($rose(syncLocked));
   cover property ($rose(overrunFlag));
   cover property ($rose(parityErrorFlag));
   cover property ($fell(fifoSpaceOk));
endmodule
bind scr_receiver scr_checker i_scr_checker (.core_clk, .reset_n, .syncHuntIn, .syncHuntOe,
   .masterClear, .chipDisableLine, .parityOffSelect, .holdData, .charReadyFlag, .overrunFlag,
   .parityErrorFlag, .matchFlag, .syncLocked, .fifoSpaceOk);

//--- tb/scr_line_model.sv
// Purpose: serial line model supplying bit clock and data
// Assumes: 800 ns bit period, clock idles high outside frames
// Notes: between frames data shows the inverse of its last bit
`timescale 1ns/1ps
module scr_line_model
(
   output logic bitClk,
   output logic dataBit
);
   initial
   begin
      bitClk = 1'b1;
      dataBit = 1'b0;
   end
   // ==========================================
   // frame sender, lsb first, fall mid-bit
   // ==========================================
   task automatic send(input logic [8:0] bits, input int n);
      #13;
      for (int i = 0; i < n; i++)
      begin
         dataBit = bits[i];
         #400 bitClk = 1'b0;
         #400 bitClk = 1'b1;
      end
      // released line must not look like a held bit
      dataBit = ~dataBit;
   endtask
endmodule

//--- tb/scr_receiver_tb_top.sv
// Purpose: self-checking bench for the sync character receiver
// Assumes: inputs change on the falling clock edge, except the line model's bit clock and data
// Notes: a queue model predicts every word leaving the fifo
`timescale 1ns/1ps
module scr_receiver_tb_top;
   logic core_clk = 1'b0, reset_n = 1'b0, masterClear = 1'b0, chipDisableLine = 1'b0;
   logic charReadyClear_n = 1'b1, statusFlagClear_n = 1'b1, matchLoadStrobe_n = 1'b1;
   logic controlLoadStrobe_n = 1'b0, evenParitySelect = 1'b0, parityOffSelect = 1'b1;
   logic syncHuntIn = 1'b0, fifoReady = 1'b0, drainOn = 1'b0;
   logic [2:0] rxModeSelect = 3'h1;
   logic [1:0] wordLengthSelect = 2'h3;
   logic [7:0] matchCharInputs = 8'h16;
   wire bitClk, dataBit, syncHuntOut, syncHuntOe, holdParity, charReadyFlag, overrunFlag;
   wire parityErrorFlag, matchFlag, framingErrorFlag, syncLocked, fifoSpaceOk, fifoValid;
   wire [7:0] holdData, fifoData;
   int err_count = 0, checked = 0;
   logic [31:0] seed = 32'd20619;
   logic [7:0] q[$];
   logic [7:0] c;
   // ==========================================
   // clock, line model and design
   // ==========================================
   always #50 core_clk = ~core_clk;
   scr_line_model i_scr_line_model (.bitClk(bitClk), .dataBit(dataBit));
   scr_receiver i_scr_receiver (.core_clk(core_clk), .reset_n(reset_n), .rxBitClock(bitClk),
      .serialRxInput(dataBit), .syncHuntIn(syncHuntIn), .syncHuntOut(syncHuntOut),
      .syncHuntOe(syncHuntOe), .masterClear(masterClear), .chipDisableLine(chipDisableLine),
      .charReadyClear_n(charReadyClear_n), .statusFlagClear_n(statusFlagClear_n),
      .controlLoadStrobe_n(controlLoadStrobe_n), .matchLoadStrobe_n(matchLoadStrobe_n),
      .evenParitySelect(evenParitySelect), .parityOffSelect(parityOffSelect),
      .rxModeSelect(rxModeSelect), .wordLengthSelect(wordLengthSelect),
      .matchCharInputs(matchCharInputs), .holdData(holdData), .holdParity(holdParity),
      .charReadyFlag(charReadyFlag), .overrunFlag(overrunFlag),
      .parityErrorFlag(parityErrorFlag), .matchFlag(matchFlag),
      .framingErrorFlag(framingErrorFlag), .syncLocked(syncLocked),
      .fifoSpaceOk(fifoSpaceOk), .fifoData(fifoData), .fifoValid(fifoValid),
      .fifoReady(fifoReady));
   // ==========================================
   // helpers
   // ==========================================
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // one character: len data bits, then parity bit when enabled
   task automatic send_char(input logic [7:0] d, input int len, input logic bad);
      logic [8:0] v;
      v = {1'b0, d & ((8'h01 << len) - 8'h01)};
      v[len] = (evenParitySelect ? ^v[7:0] : ~^v[7:0]) ^ bad;
      i_scr_line_model.send(v, len + (parityOffSelect ? 0 : 1));
      cyc(6);
   endtask
   // pulse an active-low clear for a few cycles
   task automatic pulse_clear(input logic ready);
      if (ready) charReadyClear_n = 1'b0;
      else statusFlagClear_n = 1'b0;
      cyc(4);
      charReadyClear_n = 1'b1;
      statusFlagClear_n = 1'b1;
      cyc(4);
   endtask
   task automatic print_verdict();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // fifo drain with random stalls, compared with the queue model
   // ==========================================
   always @(negedge core_clk)
      fifoReady <= drainOn & rnd() & 1'b1;
   always @(posedge core_clk)
      if (fifoValid === 1'b1 && fifoReady === 1'b1)
         check(fifoData, q.pop_front());
   initial
   begin
      #3_000_000;
      err_count++;
      print_verdict();
   end
   // ==========================================
   // main sequence
   // ==========================================
   initial
   begin
      cyc(12);
      reset_n = 1'b1;
      cyc(2);
      check(holdData, 8'hFF);
      check({syncHuntOut, syncHuntOe}, 2'b00);
      matchLoadStrobe_n = 1'b0;
      cyc(4);
      matchLoadStrobe_n = 1'b1;
      // before any hunt the holding register follows the shifter
      send_char(8'hA5, 8, 1'b0);
      check(holdData, 8'hA5);
      check(charReadyFlag, 1'b0);
      syncHuntIn = 1'b1;
      cyc(4);
      send_char(8'h16, 8, 1'b0);
      check(syncLocked, 1'b1);
      check({matchFlag, charReadyFlag}, 2'b10);
      // two characters unread make an overrun
      for (int i = 0; i < 2; i++)
      begin
         c = rnd();
         q.push_back(c);
         send_char(c, 8, 1'b0);
         check(holdData, c);
         check(matchFlag, c == 8'h16);
         check(overrunFlag, i);
      end
      chipDisableLine = 1'b1;
      cyc(5);
      check(overrunFlag, 1'b0);
      chipDisableLine = 1'b0;
      cyc(5);
      check(overrunFlag, 1'b1);
      pulse_clear(1'b0);
      check({overrunFlag, charReadyFlag}, 2'b01);
      pulse_clear(1'b1);
      check(charReadyFlag, 1'b0);
      // fill the fifo past full while it is stalled, then drain
      for (int i = 0; i < 16; i++)
      begin
         c = rnd();
         q.push_back(c);
         send_char(c, 8, 1'b0);
      end
      check(fifoSpaceOk, 1'b0);
      drainOn = 1'b1;
      cyc(100);
      check(fifoValid, 1'b0);
      check(fifoSpaceOk, 1'b1);
      q.delete();
      syncHuntIn = 1'b0;
      cyc(6);
      check(syncLocked, 1'b0);
      // every word length, odd and even, good and bad parity
      for (int w = 0; w < 4; w++)
      begin
         wordLengthSelect = w;
         parityOffSelect = 1'b1;
         // ones in the shifter keep the hunt from matching a partial window
         i_scr_line_model.send(9'h1FF, 9);
         cyc(6);
         syncHuntIn = 1'b1;
         cyc(4);
         send_char(8'h16, 5 + w, 1'b0);
         check(syncLocked, 1'b1);
         parityOffSelect = 1'b0;
         evenParitySelect = w[0];
         c = rnd();
         c = c & ((8'h01 << (5 + w)) - 8'h01);
         q.push_back(c);
         send_char(c, 5 + w, w[1]);
         check(holdData, c);
         check(parityErrorFlag, w[1]);
         check(holdParity, (w[0] ? ^c : ~^c) ^ w[1]);
         pulse_clear(1'b0);
         pulse_clear(1'b1);
         syncHuntIn = 1'b0;
         cyc(6);
      end
      // master clear idles the receiver and zeroes the match character
      parityOffSelect = 1'b1;
      masterClear = 1'b1;
      cyc(5);
      check({holdData, matchFlag, syncLocked, framingErrorFlag}, {8'hFF, 3'b000});
      masterClear = 1'b0;
      cyc(4);
      syncHuntIn = 1'b1;
      cyc(4);
      send_char(8'h00, 8, 1'b0);
      check(syncLocked, 1'b1);
      print_verdict();
   end
endmodule
